/* File: logic/tws_device.sv */
// Two-wire pointer slave: link side on link_clk, register side on clock
//
// Summary of operation
// RL1 - Target only; SDA open drain, never SCL
// RL2 - Fast and high-speed SCL rates supported
// RL3 - All bytes shifted most significant first
// RL4 - SDA fall with SCL high starts
// RL5 - SDA rise with SCL high stops
// RL6 - Address byte in, direction last, ack ninth
// RL7 - Answer only address 4Ch and general call 00h
// RL8 - Eight data clocks then receiver acknowledge
// RL9 - SDA changes only while SCL low
// RL10 - Ack held low through ack high
// RL11 - Any byte count per transfer
// RL12 - First written byte loads pointer
// RL13 - Pointer-only write is valid
// RL14 - Reads use last written pointer
// RL15 - Master nack ends device data drive
// RL16 - Stuck low 25 ms resets serial logic
// RL17 - Time-out enable input, off after reset
// RL18 - Master keeps SCL above 1 kHz
// RL19 - Master code unacked, switches to high speed
// RL20 - High speed held until stop
// RL21 - General call acked, second byte evaluated
// RL22 - Second byte 06h requests full reset
// RL23 - Pointer resets to 00h
// RL24 - Data bytes acked and written at pointer
`timescale 1ns/10ps
`include "tws_regs.svh"
module tws_device
  import tws_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = `TIMEOUT_CYCLES
)(
  // Register side
  input  wire logic        clock,
  input  wire logic        rstn,
  output logic [7:0]       reg_addr,
  output logic [7:0]       reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd,
  input  wire logic [7:0]  reg_rdata,
  output logic             soft_reset,
  output logic             hs_mode,
  input  wire logic        bus_timeout_enable,
  // Link side
  input  wire logic        link_clk,
  tws_if.device            bus
);

  dev_link_t l_r;
  dev_link_t l_nxt;
  dev_user_t u_r;
  dev_user_t u_nxt;
  logic      scl;
  logic      sda;
  logic      scl_rise;
  logic      scl_fall;
  logic      start;
  logic      stop;
  logic [1:0] lim;

  // ----------------------------------------
  // Link domain
  // ----------------------------------------
  always_comb
  begin
    l_nxt       = l_r;
    l_nxt.sync1 = {bus.scl, bus.sda};
    l_nxt.sync2 = l_r.sync1;
    l_nxt.en_s1 = bus_timeout_enable;                                  // RL17
    l_nxt.en_s2 = l_r.en_s1;
    l_nxt.ack_s1 = u_r.ack_tgl;
    l_nxt.ack_s2 = l_r.ack_s1;
    // Spike filter shortens in high speed
    lim = l_r.hs ? `FILT_HS : `FILT_FAST;                               // RL2
    for (int i = 0; i < 2; i++)
    begin
      if (l_r.sync2[i] == l_r.flt_val[i])
        l_nxt.flt_cnt[i] = 2'h0;
      else if (l_r.flt_cnt[i] >= lim)
      begin
        l_nxt.flt_val[i] = l_r.sync2[i];
        l_nxt.flt_cnt[i] = 2'h0;
      end
      else
        l_nxt.flt_cnt[i] = l_r.flt_cnt[i] + 2'h1;
    end
    l_nxt.prev = l_r.flt_val;
    scl      = l_r.flt_val[1];
    sda      = l_r.flt_val[0];
    scl_rise = scl & ~l_r.prev[1];
    scl_fall = ~scl & l_r.prev[1];
    start    = scl & l_r.prev[1] & l_r.prev[0] & ~sda;                 // RL4
    stop     = scl & l_r.prev[1] & ~l_r.prev[0] & sda;                 // RL5
    // Read data lands here; prefetched so no clock stretch is needed
    if (l_r.ack_s2 != l_r.ack_seen)
    begin
      l_nxt.ack_seen = l_r.ack_s2;
      l_nxt.txd      = u_r.rdat;
    end
    if (l_r.active && l_r.en_s2 && (!scl || !sda))
      l_nxt.to_cnt = l_r.to_cnt + 20'h1;                               // RL16
    else
      l_nxt.to_cnt = 20'h0;

    unique case (l_r.state)
      D_IDLE: ;
      D_RECV:
      begin
        if (scl_rise)
        begin
          l_nxt.shift = {l_r.shift[6:0], sda};                         // RL3
          l_nxt.cnt   = l_r.cnt + 4'h1;
        end
        if (scl_fall && l_r.cnt == `BYTE_BITS)
        begin
          l_nxt.state  = D_ACK;                                        // RL8
          l_nxt.sda_oe = 1'b1;                                         // RL9
          if (l_r.first)
          begin
            l_nxt.first = 1'b0;
            if (l_r.shift[7:1] == `DEV_ADDR)                           // RL7
            begin
              l_nxt.rw = l_r.shift[0];                                 // RL6
              if (l_r.shift[0])
                l_nxt.rd_tgl = ~l_r.rd_tgl;                            // RL14
            end
            else if (l_r.shift == `GCALL_ADDR)
              l_nxt.gc = 1'b1;                                         // RL21
            else
            begin
              l_nxt.state  = D_IDLE;
              l_nxt.sda_oe = 1'b0;
              if (l_r.shift[7:3] == `HS_CODE_TOP)
                l_nxt.hs = 1'b1;                                       // RL19
            end
          end
          else if (l_r.gc)
          begin
            if (l_r.shift == `GCALL_RESET)
            begin
              l_nxt.gr_tgl = ~l_r.gr_tgl;                              // RL22
              l_nxt.ptr    = `PTR_RESET;
            end
          end
          else if (!l_r.ptr_done)
          begin
            l_nxt.ptr      = l_r.shift;                                // RL12 RL13
            l_nxt.ptr_done = 1'b1;
          end
          else
          begin
            l_nxt.wdat   = l_r.shift;                                  // RL24
            l_nxt.wr_tgl = ~l_r.wr_tgl;
          end
        end
      end
      D_ACK:
      begin
        // Released only at the falling edge, so low spans the high phase
        if (scl_fall)                                                  // RL10
        begin
          l_nxt.cnt = 4'h0;                                            // RL11
          if (l_r.rw)
          begin
            l_nxt.state  = D_SEND;
            l_nxt.shift  = l_r.txd;
            l_nxt.sda_oe = ~l_r.txd[7];
            l_nxt.rd_tgl = ~l_r.rd_tgl;
          end
          else
          begin
            l_nxt.state  = D_RECV;
            l_nxt.sda_oe = 1'b0;
          end
        end
      end
      D_SEND:
      begin
        if (scl_rise)
          l_nxt.cnt = l_r.cnt + 4'h1;
        if (scl_fall)
        begin
          if (l_r.cnt == `BYTE_BITS)
          begin
            l_nxt.state  = D_MACK;
            l_nxt.sda_oe = 1'b0;
          end
          else
          begin
            l_nxt.shift  = {l_r.shift[6:0], 1'b0};                     // RL3
            l_nxt.sda_oe = ~l_r.shift[6];                              // RL9
          end
        end
      end
      D_MACK:
      begin
        if (scl_rise)
          l_nxt.ack_ok = ~sda;
        if (scl_fall)
        begin
          l_nxt.cnt = 4'h0;
          if (l_r.ack_ok)
          begin
            l_nxt.state  = D_SEND;
            l_nxt.shift  = l_r.txd;
            l_nxt.sda_oe = ~l_r.txd[7];
            l_nxt.rd_tgl = ~l_r.rd_tgl;
          end
          else
            l_nxt.state = D_IDLE;                                      // RL15
        end
      end
    endcase

    if (start)
    begin
      l_nxt.state    = D_RECV;
      l_nxt.cnt      = 4'h0;
      l_nxt.first    = 1'b1;
      l_nxt.gc       = 1'b0;
      l_nxt.rw       = 1'b0;
      l_nxt.ptr_done = 1'b0;
      l_nxt.sda_oe   = 1'b0;
      l_nxt.active   = 1'b1;
    end
    if (stop || l_r.to_cnt >= 20'(TIMEOUT_CYCLES - 1))                 // RL16
    begin
      l_nxt.state  = D_IDLE;
      l_nxt.sda_oe = 1'b0;
      l_nxt.active = 1'b0;
    end
    if (stop)
      l_nxt.hs = 1'b0;                                                 // RL20
  end

  always_ff @(posedge link_clk or negedge rstn)
  begin
    if (!rstn)
      l_r <= '0;                                                       // RL23
    else
      l_r <= l_nxt;
  end

  // ----------------------------------------
  // Register domain
  // ----------------------------------------
  always_comb
  begin
    u_nxt            = u_r;
    u_nxt.wr_s1      = l_r.wr_tgl;
    u_nxt.wr_s2      = u_r.wr_s1;
    u_nxt.rd_s1      = l_r.rd_tgl;
    u_nxt.rd_s2      = u_r.rd_s1;
    u_nxt.gr_s1      = l_r.gr_tgl;
    u_nxt.gr_s2      = u_r.gr_s1;
    u_nxt.hs_s1      = l_r.hs;
    u_nxt.hs_s2      = u_r.hs_s1;
    u_nxt.reg_wr     = 1'b0;
    u_nxt.reg_rd     = 1'b0;
    u_nxt.soft_reset = 1'b0;
    // Pointer and data are stable long before and after each toggle
    if (u_r.wr_s2 != u_r.wr_seen)
    begin
      u_nxt.wr_seen   = u_r.wr_s2;
      u_nxt.reg_addr  = l_r.ptr;                                       // RL24
      u_nxt.reg_wdata = l_r.wdat;
      u_nxt.reg_wr    = 1'b1;
    end
    else if (u_r.rd_s2 != u_r.rd_seen)
    begin
      u_nxt.rd_seen  = u_r.rd_s2;
      u_nxt.reg_addr = l_r.ptr;                                        // RL14
      u_nxt.reg_rd   = 1'b1;
    end
    if (u_r.reg_rd)
    begin
      u_nxt.rdat    = reg_rdata;
      u_nxt.ack_tgl = ~u_r.ack_tgl;
    end
    if (u_r.gr_s2 != u_r.gr_seen)
    begin
      u_nxt.gr_seen    = u_r.gr_s2;
      u_nxt.soft_reset = 1'b1;                                         // RL22
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      u_r <= '0;
    else
      u_r <= u_nxt;
  end

  assign reg_addr     = u_r.reg_addr;
  assign reg_wdata    = u_r.reg_wdata;
  assign reg_wr       = u_r.reg_wr;
  assign reg_rd       = u_r.reg_rd;
  assign soft_reset   = u_r.soft_reset;
  assign hs_mode      = u_r.hs_s2;
  assign bus.d_sda_o  = 1'b0;
  assign bus.d_sda_oe = l_r.sda_oe;                                    // RL1

endmodule // tws_device

/* File: logic/tws_regs.svh */
// Constants for the two-wire pointer slave and its bus master
`ifndef TWS_REGS_SVH
`define TWS_REGS_SVH
`define DEV_ADDR        7'h4c
`define GCALL_ADDR      8'h00
`define GCALL_RESET     8'h06
`define HS_CODE_TOP     5'h01
`define PTR_RESET       8'h00
`define BYTE_BITS       4'h8
`define QTR_LAST        2'h3
`define FILT_FAST       2'h2
`define FILT_HS         2'h0
`define TIMEOUT_US      25000
`define LINK_PERIOD_NS  32
`define TIMEOUT_CYCLES  ((`TIMEOUT_US * 1000) / `LINK_PERIOD_NS)
`define CLK_KHZ         25000
`define SCL_FAST_KHZ    400
`define SCL_QTR_CYCLES  ((`CLK_KHZ + 4 * `SCL_FAST_KHZ - 1) / (4 * `SCL_FAST_KHZ))
`endif

/* File: logic/tws_pkg.sv */
// Types shared by both ends of the two-wire link
package tws_pkg;

  typedef enum logic [2:0] {D_IDLE, D_RECV, D_ACK, D_SEND, D_MACK} dev_state_t;
  typedef enum logic [1:0] {M_IDLE, M_START, M_BIT, M_STOP} mst_state_t;

  typedef struct packed {
    dev_state_t       state;
    logic [1:0]       sync1;
    logic [1:0]       sync2;
    logic [1:0]       flt_val;
    logic [1:0][1:0]  flt_cnt;
    logic [1:0]       prev;
    logic [7:0]       shift;
    logic [3:0]       cnt;
    logic             first;
    logic             gc;
    logic             rw;
    logic             ptr_done;
    logic             ack_ok;
    logic [7:0]       ptr;
    logic [7:0]       wdat;
    logic [7:0]       txd;
    logic             sda_oe;
    logic             hs;
    logic             active;
    logic [19:0]      to_cnt;
    logic             wr_tgl;
    logic             rd_tgl;
    logic             gr_tgl;
    logic             ack_s1;
    logic             ack_s2;
    logic             ack_seen;
    logic             en_s1;
    logic             en_s2;
  } dev_link_t;

  typedef struct packed {
    logic             wr_s1;
    logic             wr_s2;
    logic             wr_seen;
    logic             rd_s1;
    logic             rd_s2;
    logic             rd_seen;
    logic             gr_s1;
    logic             gr_s2;
    logic             gr_seen;
    logic             hs_s1;
    logic             hs_s2;
    logic [7:0]       rdat;
    logic             ack_tgl;
    logic [7:0]       reg_addr;
    logic [7:0]       reg_wdata;
    logic             reg_wr;
    logic             reg_rd;
    logic             soft_reset;
  } dev_user_t;

  typedef struct packed {
    mst_state_t       state;
    logic             sync1;
    logic             sync2;
    logic [4:0]       qcnt;
    logic [1:0]       qtr;
    logic [3:0]       bitn;
    logic [7:0]       shift;
    logic             rx;
    logic             nack;
    logic             stop;
    logic             held;
    logic             scl_oe;
    logic             sda_oe;
    logic             rsp_valid;
    logic [7:0]       rsp_byte;
    logic             rsp_ack;
  } mst_t;

endpackage

/* File: logic/tws_if.sv */
// Open-drain two-wire bus joining master and device
`timescale 1ns/10ps
interface tws_if;
  logic scl_o;
  logic scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic d_sda_o;
  logic d_sda_oe;
  logic scl;
  logic sda;

  // Wired-AND with pull-ups
  assign scl = ~(scl_oe & ~scl_o);
  assign sda = ~((m_sda_oe & ~m_sda_o) | (d_sda_oe & ~d_sda_o));

  modport master (output scl_o, output scl_oe, output m_sda_o, output m_sda_oe,
                  input scl, input sda);
  modport device (output d_sda_o, output d_sda_oe, input scl, input sda);
endinterface // tws_if

/* File: logic/tws_master.sv */
// Byte-level two-wire bus master driving SCL from a divider
`timescale 1ns/10ps
`include "tws_regs.svh"
module tws_master
  import tws_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rstn,
  // Byte command
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire logic        cmd_start,
  input  wire logic        cmd_stop,
  input  wire logic        cmd_rx,
  input  wire logic        cmd_nack,
  input  wire logic [7:0]  cmd_byte,
  // Byte result
  output logic             rsp_valid,
  output logic [7:0]       rsp_byte,
  output logic             rsp_ack,
  // Bus
  tws_if.master            bus
);

  mst_t r;
  mst_t n;
  logic tick;

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb
  begin
    n           = r;
    n.sync1     = bus.sda;
    n.sync2     = r.sync1;
    n.rsp_valid = 1'b0;
    // Quarter-period divider keeps SCL at or below fast-mode rate
    tick   = (r.qcnt == 5'(`SCL_QTR_CYCLES - 1));                    // RL2 RL18
    n.qcnt = (tick || r.state == M_IDLE) ? 5'h0 : r.qcnt + 5'h1;
    unique case (r.state)
      M_IDLE:
      begin
        if (cmd_valid)
        begin
          n.shift = cmd_byte;
          n.rx    = cmd_rx;
          n.nack  = cmd_nack;
          n.stop  = cmd_stop;
          n.qtr   = 2'h0;
          n.bitn  = 4'h0;
          n.held  = 1'b1;
          n.state = cmd_start ? M_START : M_BIT;
        end
      end
      M_START:
      begin
        if (tick)
        begin
          n.qtr = r.qtr + 2'h1;
          if (r.qtr == `QTR_LAST)
            n.state = M_BIT;
        end
      end
      M_BIT:
      begin
        if (tick)
        begin
          n.qtr = r.qtr + 2'h1;
          if (r.qtr == `QTR_LAST)
          begin
            if (r.bitn == `BYTE_BITS)
            begin
              n.rsp_valid = 1'b1;
              n.rsp_byte  = r.shift;
              n.rsp_ack   = ~r.sync2;
              n.state     = r.stop ? M_STOP : M_IDLE;
            end
            else
            begin
              n.shift = {r.shift[6:0], r.sync2};                       // RL3
              n.bitn  = r.bitn + 4'h1;
            end
          end
        end
      end
      M_STOP:
      begin
        if (tick)
        begin
          n.qtr = r.qtr + 2'h1;
          if (r.qtr == `QTR_LAST)
          begin
            n.state = M_IDLE;
            n.held  = 1'b0;
          end
        end
      end
    endcase

    // Pin drive follows the quarter; SDA moves in quarters with SCL low, except at the start and stop edges where SCL is high
    unique case (n.state)
      M_IDLE:
        n.scl_oe = n.held;
      M_START:
      begin
        n.scl_oe = (n.qtr == 2'h0) || (n.qtr == `QTR_LAST);
        n.sda_oe = n.qtr[1];                                           // RL4
      end
      M_BIT:
      begin
        n.scl_oe = ~n.qtr[1];
        if (n.qtr == 2'h0)                                             // RL9
        begin
          if (n.bitn == `BYTE_BITS)
            n.sda_oe = n.rx & ~n.nack;                                 // RL8 RL15
          else
            n.sda_oe = ~n.rx & ~n.shift[7];
        end
      end
      M_STOP:
      begin
        n.scl_oe = (n.qtr == 2'h0);
        n.sda_oe = ~n.qtr[1];                                          // RL5
      end
    endcase
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      r <= '0;
    else
      r <= n;
  end

  assign cmd_ready    = (r.state == M_IDLE);
  assign rsp_valid    = r.rsp_valid;
  assign rsp_byte     = r.rsp_byte;
  assign rsp_ack      = r.rsp_ack;
  assign bus.scl_o    = 1'b0;
  assign bus.scl_oe   = r.scl_oe;
  assign bus.m_sda_o  = 1'b0;
  assign bus.m_sda_oe = r.sda_oe;

endmodule // tws_master

/* File: dv/tws_props.sv */
// Link checker for the two-wire pointer slave
`timescale 1ns/10ps
module tws_props (
  // Clock and reset
  input wire logic link_clk,
  input wire logic rstn,
  // Bus
  input wire logic scl_oe,
  input wire logic d_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  // --------------------------------
  // Bus tracker
  // --------------------------------
  logic       scl_r, sda_r, act_r, first_r;
  logic       mine_r, rd_r, done_r;
  logic [3:0] cnt_r;
  logic [7:0] sh_r;
  logic       rise;

  // Start and stop rises are counted too, but a start clears the count and a stop clears act_r and done_r
  assign rise = scl & ~scl_r;

  always_ff @(posedge link_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      {scl_r, sda_r} <= 2'h3;
      {act_r, first_r, mine_r, rd_r, done_r} <= 5'h00;
      cnt_r <= 4'h0;
      sh_r  <= 8'h00;
    end
    else
    begin
      scl_r <= scl;
      sda_r <= sda;
      if (scl && scl_r && sda_r && !sda)
      begin
        {act_r, first_r, done_r} <= 3'h6;
        cnt_r <= 4'h0;
      end
      else if (scl && scl_r && !sda_r && sda)
        {act_r, done_r} <= 2'h0;
      else if (rise && act_r && cnt_r == 4'h8)
      begin
        cnt_r   <= 4'h0;
        first_r <= 1'h0;
        if (first_r)
        begin
          mine_r <= (sh_r[7:1] == 7'h4c) || (sh_r == 8'h00);
          rd_r   <= sh_r[0];
        end
        if (mine_r && rd_r && !first_r && sda)
          done_r <= 1'h1;
      end
      else if (rise && act_r)
      begin
        cnt_r <= cnt_r + 4'h1;
        sh_r  <= {sh_r[6:0], sda};
      end
    end
  end

  default clocking cb @(posedge link_clk); endclocking
  default disable iff (!rstn);

  property p_no_scl;
    !scl |-> scl_oe;
  endproperty
  a_no_scl: assert property (p_no_scl) else $error("scl low undriven");
  property p_quiet_idle;
    !act_r |-> !d_sda_oe;
  endproperty
  a_quiet_idle: assert property (p_quiet_idle) else $error("sda driven idle");
  property p_stable_high;
    scl && scl_r |-> $stable(d_sda_oe);
  endproperty
  a_stable_high: assert property (p_stable_high) else $error("sda moved scl high");
  property p_ack_hold;
    rise && d_sda_oe |-> d_sda_oe [*8];
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("low not held");
  property p_addr_ack;
    rise && act_r && first_r && cnt_r == 4'h8 |->
      d_sda_oe == ((sh_r[7:1] == 7'h4c) || (sh_r == 8'h00));
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("address ack wrong");
  property p_write_ack;
    rise && cnt_r == 4'h8 && !first_r && mine_r && !rd_r |-> d_sda_oe;
  endproperty
  a_write_ack: assert property (p_write_ack) else $error("data byte unacked");
  property p_read_slot;
    rise && cnt_r == 4'h8 && !first_r && mine_r && rd_r |-> !d_sda_oe;
  endproperty
  a_read_slot: assert property (p_read_slot) else $error("ack slot driven");
  property p_nack_quiet;
    done_r |-> !d_sda_oe;
  endproperty
  a_nack_quiet: assert property (p_nack_quiet) else $error("drive after nack");
endmodule // tws_props

/* File: dv/two_wire_pointer_slave_test.sv */
// Testbench joining the two-wire master and pointer slave
`timescale 1ns/10ps
module two_wire_pointer_slave_test;
  logic       clock, link_clk, rstn, bus_timeout_enable;
  logic       cmd_valid, cmd_ready, cmd_start, cmd_stop, cmd_rx, cmd_nack;
  logic       rsp_valid, rsp_ack, reg_wr, reg_rd, soft_reset, hs_mode;
  logic [7:0] cmd_byte, rsp_byte, reg_addr, reg_wdata, reg_rdata;
  logic [7:0] got_b, got_a;
  logic [7:0] mem [256];
  int         wr_count, sr_count, bad_count, samples_checked;

  initial clock = 1'h0;
  initial link_clk = 1'h1;
  always #20 clock = ~clock;
  always #16 link_clk = ~link_clk;

  // --------------------------------
  // Register file beside the slave
  // --------------------------------
  assign reg_rdata = mem[reg_addr];
  always @(posedge clock)
  begin
    if (reg_wr === 1'h1)
    begin
      mem[reg_addr] <= reg_wdata;
      wr_count <= wr_count + 1;
    end
    if (soft_reset === 1'h1)
      sr_count <= sr_count + 1;
  end

  tws_if tws_if_i ();
  tws_master tws_master_i (
    .clock(clock), .rstn(rstn), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_start(cmd_start), .cmd_stop(cmd_stop), .cmd_rx(cmd_rx), .cmd_nack(cmd_nack),
    .cmd_byte(cmd_byte), .rsp_valid(rsp_valid), .rsp_byte(rsp_byte),
    .rsp_ack(rsp_ack), .bus(tws_if_i.master)
  );
  // Short time-out, longer than the SDA low run of address byte 98h and its ack, but not of nine low bits
  tws_device #(.TIMEOUT_CYCLES(600)) tws_device_i (
    .clock(clock), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .soft_reset(soft_reset), .hs_mode(hs_mode),
    .bus_timeout_enable(bus_timeout_enable), .link_clk(link_clk),
    .bus(tws_if_i.device)
  );
  tws_props tws_props_i (
    .link_clk(link_clk), .rstn(rstn), .scl_oe(tws_if_i.scl_oe),
    .d_sda_oe(tws_if_i.d_sda_oe), .scl(tws_if_i.scl), .sda(tws_if_i.sda)
  );

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic hang(input string what);
    bad_count++;
    $display("Error %s expected done seen timeout", what);
    report_and_stop();
  endtask

  // Flags are start, stop, receive, nack
  task automatic xfer(input logic [3:0] f, input logic [7:0] b);
    int i;
    @(posedge clock);
    #1;
    cmd_valid = 1'h1;
    {cmd_start, cmd_stop, cmd_rx, cmd_nack} = f;
    cmd_byte = b;
    for (i = 0; i < 5000 && cmd_ready !== 1'h1; i++)
    begin
      @(posedge clock);
      #1;
    end
    if (i == 5000)
      hang("cmd_ready");
    @(posedge clock);
    #1;
    cmd_valid = 1'h0;
    // Pulse is looked at once settled, not in the edge that launches it
    for (i = 0; i < 5000 && rsp_valid !== 1'h1; i++)
    begin
      @(posedge clock);
      #1;
    end
    if (i == 5000)
      hang("rsp_valid");
    got_b = rsp_byte;
    got_a = {7'h00, rsp_ack};
  endtask

  task automatic wait_hs(input logic exp);
    int i;
    for (i = 0; i < 300 && hs_mode !== exp; i++)
    begin
      @(posedge clock);
      #1;
    end
    if (i == 300)
      hang("hs_mode");
  endtask

  // Pointer leaves reset at 00h, so a read needs no pointer byte
  task automatic t_por();
    check("reg_addr", reg_addr, 8'h00);
    check("hs_mode", {7'h00, hs_mode}, 8'h00);
    xfer(4'h8, 8'h99);
    xfer(4'h7, 8'hff);
    check("rd byte", got_b, 8'h5a);
  endtask

  task automatic t_write();
    xfer(4'h8, 8'h98);
    check("addr ack", got_a, 8'h01);
    xfer(4'h0, 8'h05);
    check("ptr ack", got_a, 8'h01);
    xfer(4'h0, 8'h0a);
    check("reg 05", mem[8'h05], 8'h0a);
    xfer(4'h4, 8'h3c);
    check("data ack", got_a, 8'h01);
    check("reg 05", mem[8'h05], 8'h3c);
    check("writes", wr_count[7:0], 8'h02);
  endtask

  task automatic t_read();
    xfer(4'h8, 8'h98);
    xfer(4'h4, 8'h07);
    check("ptr ack", got_a, 8'h01);
    xfer(4'h8, 8'h99);
    xfer(4'h2, 8'hff);
    check("rd byte", got_b, 8'h5d);
    xfer(4'h7, 8'hff);
    check("rd byte", got_b, 8'h5d);
    check("release", {7'h00, tws_if_i.d_sda_oe}, 8'h00);
    xfer(4'h8, 8'h98);
    xfer(4'h0, 8'h09);
    xfer(4'h8, 8'h99);
    xfer(4'h7, 8'hff);
    check("rd byte", got_b, 8'h53);
    xfer(4'h8, 8'h99);
    xfer(4'h7, 8'hff);
    check("rd byte", got_b, 8'h53);
  endtask

  task automatic t_misc();
    logic [7:0] other [4] = '{8'h9a, 8'h18, 8'hd8, 8'h9c};
    foreach (other[k])
    begin
      xfer(4'hc, other[k]);
      check("foreign nack", got_a, 8'h00);
    end
    xfer(4'h8, 8'h00);
    check("gc ack", got_a, 8'h01);
    xfer(4'h4, 8'h12);
    check("resets", sr_count[7:0], 8'h00);
    xfer(4'h8, 8'h00);
    xfer(4'h4, 8'h06);
    check("resets", sr_count[7:0], 8'h01);
    xfer(4'h8, 8'h99);
    xfer(4'h7, 8'hff);
    check("rd byte", got_b, 8'h5a);
  endtask

  task automatic t_hs();
    for (int k = 0; k < 8; k++)
    begin
      xfer(4'h8, 8'h08 + k[7:0]);
      check("code nack", got_a, 8'h00);
      wait_hs(1'h1);
      check("hs_mode", {7'h00, hs_mode}, 8'h01);
      xfer(4'h8, 8'h98);
      xfer(4'h4, 8'h03);
      check("hs_mode", {7'h00, hs_mode}, 8'h01);
      wait_hs(1'h0);
      check("hs_mode", {7'h00, hs_mode}, 8'h00);
    end
  endtask

  // Pointer 00h holds a byte with a low top bit, so the slave pins SDA
  task automatic t_timeout();
    int i;
    xfer(4'h8, 8'h98);
    xfer(4'h4, 8'h00);
    xfer(4'h8, 8'h99);
    repeat (400) @(posedge clock);
    check("held", {7'h00, tws_if_i.d_sda_oe}, 8'h01);
    #1;
    bus_timeout_enable = 1'h1;
    for (i = 0; i < 1000 && tws_if_i.d_sda_oe !== 1'h0; i++)
    begin
      @(posedge clock);
      #1;
    end
    if (i == 1000)
      hang("release");
    check("sda", {7'h00, tws_if_i.sda}, 8'h01);
    xfer(4'hc, 8'h98);
    check("addr ack", got_a, 8'h01);
  endtask

  initial
  begin
    for (int j = 0; j < 256; j++)
      mem[j] = 8'h5a ^ j[7:0];
    {wr_count, sr_count, bad_count, samples_checked} = '0;
    {rstn, bus_timeout_enable, cmd_valid} = 3'h0;
    {cmd_start, cmd_stop, cmd_rx, cmd_nack} = 4'h0;
    cmd_byte = 8'h00;
    repeat (12) @(posedge clock);
    #1;
    rstn = 1'h1;
    repeat (20) @(posedge clock);
    t_por();
    t_write();
    t_read();
    t_misc();
    t_hs();
    t_timeout();
    report_and_stop();
  end
endmodule // two_wire_pointer_slave_test
